// file: logic/ehp_pkg.sv
`default_nettype none
package ehp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 11;
  localparam int FIFO_DEPTH = 2;
  // bit positions inside the synchronised pin vector
  localparam int PIN_CS = 0;
  localparam int PIN_A0 = 1;
  localparam int PIN_RD = 2;
  localparam int PIN_WR = 3;
  localparam int PIN_DACK = 4;
  localparam int PIN_TC = 5;
  localparam int PIN_STSEL = 6;
  localparam int PIN_DQ = 7;
  localparam int PIN_W = 15;
  // strobes, chip select and acknowledge idle high
  localparam logic [PIN_W-1:0] PIN_RST = 15'h001d;
  // host interrupt pin source select
  localparam logic [1:0] IRQ_SEL_TX = 2'h0;
  localparam logic [1:0] IRQ_SEL_RX = 2'h1;
  localparam logic [1:0] IRQ_SEL_MREQ = 2'h2;
  // status byte layout
  localparam int STAT_RX_FULL = 0;
  localparam int STAT_TX_FULL = 1;
  localparam logic [DATA_W-1:0] STAT_ZERO = 8'h00;
  // cycle budget of one memory path transfer
  localparam int RAM_XFER_CLKS = 2;
  localparam int USB_WAIT_MAX = 2;
  typedef enum logic [1:0] {EHP_IDLE, EHP_WAIT, EHP_LOAD} ehp_fetch_t;
endpackage
`default_nettype wire

// file: logic/ehp_pair_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ehp_pair_fifo #(
  parameter int W = 8,
  parameter int D = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam logic [PW:0] CNT_MAX = (PW+1)'(D);
  localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
  localparam logic [PW-1:0] PTR_ZERO = '0;
  localparam logic [PW-1:0] PTR_ONE = PW'(1);
  localparam logic [PW:0] CNT_ONE = (PW+1)'(1);

  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [PW:0] cnt_q;
  logic push, pop;

  // honest flags: full only when every slot holds a word
  assign in_ready_o = (cnt_q != CNT_MAX);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PTR_LAST) ? PTR_ZERO : p + PTR_ONE;
  endfunction

  // storage has no reset, the count guards every read
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= next_ptr(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + CNT_ONE;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - CNT_ONE;
      end
    end
  end
endmodule // ehp_pair_fifo
`default_nettype wire

// file: logic/ehp_external_host_port.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - processor path bytes are handled by on-chip interrupt-driven software
// - memory path moves bytes between host and RAM without processor help
// - burst setting runs memory path transfers back to back at full rate
// - strobe rising edge is synchronised, RAM move finishes within two clocks
// - USB owns RAM first, adding up to two clocks of wait
// - four control inputs, eight data lines, one interrupt output to host
// - DMA request, acknowledge, terminal count, status select enabled one by one
// - address bit 0 high hits processor path with interrupt, low hits RAM path
// - RAM address starts at begin address, increments per access to end
// - access under DMA acknowledge low behaves as memory path access
// - request pulses per byte without burst, stays high across burst
module ehp_external_host_port (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ext_chip_select_n_i,
  input wire logic ext_addr_bit0_i,
  input wire logic ext_read_strobe_n_i,
  input wire logic ext_write_strobe_n_i,
  input wire logic [7:0] host_data_lines_i,
  output logic [7:0] host_data_lines_o,
  output logic host_data_lines_oe_o,
  output logic host_irq_out_o,
  output logic dma_request_out_o,
  input wire logic dma_ack_in_n_i,
  input wire logic terminal_count_in_i,
  input wire logic status_select_in_i,
  input wire logic dma_req_en_i,
  input wire logic dma_ack_en_i,
  input wire logic tc_en_i,
  input wire logic status_sel_en_i,
  input wire logic port_dreq_i,
  output logic [2:0] port_in_o,
  input wire logic [1:0] irq_sel_i,
  input wire logic mem_en_i,
  input wire logic mem_read_dir_i,
  input wire logic burst_i,
  input wire logic [10:0] begin_addr_i,
  input wire logic [10:0] end_addr_i,
  output logic mem_done_o,
  output logic cpu_irq_o,
  output logic [7:0] cpu_rx_data_o,
  output logic cpu_rx_full_o,
  input wire logic cpu_rx_take_i,
  input wire logic cpu_tx_load_i,
  input wire logic [7:0] cpu_tx_data_i,
  output logic cpu_tx_full_o,
  input wire logic usb_busy_i,
  output logic ram_we_o,
  output logic ram_re_o,
  output logic [10:0] ram_addr_o,
  output logic [7:0] ram_wdata_o,
  input wire logic [7:0] ram_rdata_i
);
  localparam int DW = ehp_pkg::DATA_W;
  localparam int AW = ehp_pkg::ADDR_W;
  localparam logic [AW-1:0] ADDR_ONE = 11'h001;

  logic [ehp_pkg::PIN_W-1:0] sync1_q, sync2_q, prev_q;
  logic [DW-1:0] rxbuf_q, txbuf_q, wdata, fifo_data, fifo_head;
  logic rx_full_q, tx_valid_q, rx_pend_q, done_q, mreq_q, acc_q;
  logic [AW-1:0] addr_q;
  ehp_pkg::ehp_fetch_t st_q;
  logic wr_rise, rd_rise, mem_fall, cpu_sel, mem_sel;
  logic wr_cpu_ev, rd_cpu_ev, wr_mem_ev, rd_mem_ev, tc_hit;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic issue_wr, issue_rd, fetch_load, byte_ready;

  function automatic logic sel_mem(input logic [ehp_pkg::PIN_W-1:0] v, input logic ack_en);
    sel_mem = (ack_en && !v[ehp_pkg::PIN_DACK]) ||
              (!v[ehp_pkg::PIN_CS] && !v[ehp_pkg::PIN_A0]);
  endfunction

  function automatic logic sel_cpu(input logic [ehp_pkg::PIN_W-1:0] v, input logic ack_en);
    sel_cpu = !(ack_en && !v[ehp_pkg::PIN_DACK]) &&
              !v[ehp_pkg::PIN_CS] && v[ehp_pkg::PIN_A0];
  endfunction

  function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
    addr_inc = a + ADDR_ONE;
  endfunction

  // two flops on every pin, a third only for edge history and
  // for the decode of select, terminal count and data as they stood during the strobe
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= ehp_pkg::PIN_RST;
      sync2_q <= ehp_pkg::PIN_RST;
      prev_q <= ehp_pkg::PIN_RST;
    end else begin
      sync1_q <= {host_data_lines_i, status_select_in_i, terminal_count_in_i,
                  dma_ack_in_n_i, ext_write_strobe_n_i, ext_read_strobe_n_i,
                  ext_addr_bit0_i, ext_chip_select_n_i};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // command decode on the synchronised rising edge of a strobe
  assign wr_rise = sync2_q[ehp_pkg::PIN_WR] && !prev_q[ehp_pkg::PIN_WR];
  assign rd_rise = sync2_q[ehp_pkg::PIN_RD] && !prev_q[ehp_pkg::PIN_RD];
  assign mem_sel = sel_mem(prev_q, dma_ack_en_i);
  assign cpu_sel = sel_cpu(prev_q, dma_ack_en_i);
  assign wr_cpu_ev = wr_rise && cpu_sel;
  assign rd_cpu_ev = rd_rise && cpu_sel;
  // a disabled or finished memory path ignores the host
  assign wr_mem_ev = wr_rise && mem_sel && mem_en_i && !done_q && !mem_read_dir_i;
  assign rd_mem_ev = rd_rise && mem_sel && mem_en_i && !done_q && mem_read_dir_i;
  assign tc_hit = tc_en_i && prev_q[ehp_pkg::PIN_TC] && (wr_mem_ev || rd_mem_ev);
  assign mem_fall = sel_mem(sync2_q, dma_ack_en_i) &&
    ((!sync2_q[ehp_pkg::PIN_WR] && prev_q[ehp_pkg::PIN_WR]) ||
     (!sync2_q[ehp_pkg::PIN_RD] && prev_q[ehp_pkg::PIN_RD]));
  assign wdata = prev_q[ehp_pkg::PIN_DQ +: DW];

  // shared receive buffer; a new host write beats a processor take
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxbuf_q <= 8'h00;
      rx_full_q <= 1'b0;
      rx_pend_q <= 1'b0;
    end else begin
      if (wr_cpu_ev || wr_mem_ev) begin
        rxbuf_q <= wdata;
      end
      if (wr_cpu_ev) begin
        rx_full_q <= 1'b1;
      end else if (cpu_rx_take_i) begin
        rx_full_q <= 1'b0;
      end
      // a byte the buffer could not take waits here; one more host write while it waits loses a byte
      if (fifo_in_ready) begin
        rx_pend_q <= 1'b0;
      end else if (wr_mem_ev) begin
        rx_pend_q <= 1'b1;
      end
    end
  end

  assign fifo_in_valid = wr_mem_ev || rx_pend_q;
  assign fifo_data = rx_pend_q ? rxbuf_q : wdata;
  // USB has the RAM first, so the drain side stalls while it is busy
  assign fifo_out_ready = !usb_busy_i && !mem_read_dir_i;
  assign issue_wr = fifo_out_valid && fifo_out_ready;

  ehp_pair_fifo #(
    .W(DW),
    .D(ehp_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_head)
  );

  // RAM reads prefetch the next byte as soon as the transmit buffer empties
  assign issue_rd = (st_q == ehp_pkg::EHP_IDLE) && mem_en_i && mem_read_dir_i &&
                    !done_q && (!tx_valid_q || rd_mem_ev) && !usb_busy_i;
  assign fetch_load = (st_q == ehp_pkg::EHP_LOAD);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ehp_pkg::EHP_IDLE;
    end else begin
      case (st_q)
        ehp_pkg::EHP_IDLE: begin
          if (issue_rd) begin
            st_q <= ehp_pkg::EHP_WAIT;
          end
        end
        ehp_pkg::EHP_WAIT: st_q <= ehp_pkg::EHP_LOAD;
        ehp_pkg::EHP_LOAD: st_q <= ehp_pkg::EHP_IDLE;
        default: st_q <= ehp_pkg::EHP_IDLE;
      endcase
    end
  end

  // RAM strobes, one access per cycle at most; write data is registered
  // with the strobe so the RAM sees byte, address and enable in one cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_we_o <= 1'b0;
      ram_re_o <= 1'b0;
      ram_addr_o <= 11'h000;
      ram_wdata_o <= 8'h00;
    end else begin
      ram_we_o <= issue_wr;
      ram_re_o <= issue_rd;
      if (issue_wr || issue_rd) begin
        ram_addr_o <= addr_q;
      end
      if (issue_wr) begin
        ram_wdata_o <= fifo_head;
      end
    end
  end

  // address counter: loads while the path is off, counts per access
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= 11'h000;
      done_q <= 1'b0;
    end else if (!mem_en_i) begin
      addr_q <= begin_addr_i;
      done_q <= 1'b0;
    end else begin
      if (issue_wr || issue_rd) begin
        addr_q <= addr_inc(addr_q);
      end
      if (((issue_wr || issue_rd) && addr_q == end_addr_i) || tc_hit) begin
        done_q <= 1'b1;
      end
    end
  end

  // shared transmit buffer; a fresh load beats the host read that empties it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      txbuf_q <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      if (cpu_tx_load_i) begin
        txbuf_q <= cpu_tx_data_i;
        tx_valid_q <= 1'b1;
      end else if (fetch_load) begin
        txbuf_q <= ram_rdata_i;
        tx_valid_q <= 1'b1;
      end else if (rd_cpu_ev || rd_mem_ev) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // memory request: level in burst, one pulse per byte otherwise
  assign byte_ready = mem_read_dir_i ? tx_valid_q : (fifo_in_ready && !rx_pend_q);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mreq_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      if (mem_fall) begin
        acc_q <= 1'b1;
      end else if (wr_rise || rd_rise) begin
        acc_q <= 1'b0;
      end
      if (!mem_en_i || done_q) begin
        mreq_q <= 1'b0;
      end else if (burst_i) begin
        mreq_q <= 1'b1;
      end else begin
        // the host drops the request by starting the access
        mreq_q <= byte_ready && !acc_q && !mem_fall && !wr_rise && !rd_rise;
      end
    end
  end

  // pins and processor side, all registered
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_data_lines_o <= 8'h00;
      host_data_lines_oe_o <= 1'b0;
      host_irq_out_o <= 1'b0;
      dma_request_out_o <= 1'b0;
      port_in_o <= 3'h0;
      cpu_irq_o <= 1'b0;
      mem_done_o <= 1'b0;
    end else begin
      host_data_lines_oe_o <= !sync2_q[ehp_pkg::PIN_RD] &&
        (sel_mem(sync2_q, dma_ack_en_i) || sel_cpu(sync2_q, dma_ack_en_i));
      if (status_sel_en_i && sync2_q[ehp_pkg::PIN_STSEL]) begin
        host_data_lines_o <= ehp_pkg::STAT_ZERO;
        host_data_lines_o[ehp_pkg::STAT_RX_FULL] <= rx_full_q;
        host_data_lines_o[ehp_pkg::STAT_TX_FULL] <= tx_valid_q;
      end else begin
        host_data_lines_o <= txbuf_q;
      end
      case (irq_sel_i)
        ehp_pkg::IRQ_SEL_TX: host_irq_out_o <= tx_valid_q;
        ehp_pkg::IRQ_SEL_RX: host_irq_out_o <= !rx_full_q;
        ehp_pkg::IRQ_SEL_MREQ: host_irq_out_o <= mreq_q;
        default: host_irq_out_o <= 1'b0;
      endcase
      dma_request_out_o <= dma_req_en_i ? mreq_q : port_dreq_i;
      port_in_o <= {sync2_q[ehp_pkg::PIN_STSEL], sync2_q[ehp_pkg::PIN_TC],
                    sync2_q[ehp_pkg::PIN_DACK]};
      cpu_irq_o <= wr_cpu_ev || rd_cpu_ev;
      mem_done_o <= done_q;
    end
  end

  assign cpu_rx_data_o = rxbuf_q;
  assign cpu_rx_full_o = rx_full_q;
  assign cpu_tx_full_o = tx_valid_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fetch;
    ##[1:3] ram_re_o ##2 tx_valid_q;
  endsequence
  property p_cpu_irq;
    (wr_cpu_ev || rd_cpu_ev) |=> cpu_irq_o;
  endproperty
  a_cpu_irq: assert property (p_cpu_irq) else $error("processor access gave no irq");
  property p_mem_no_irq;
    (wr_mem_ev || rd_mem_ev) |=> !cpu_irq_o;
  endproperty
  a_mem_no_irq: assert property (p_mem_no_irq) else $error("memory access raised irq");
  property p_wr_ram;
    (wr_mem_ev && !fifo_out_valid && !usb_busy_i) ##1 !usb_busy_i |=> ram_we_o;
  endproperty
  a_wr_ram: assert property (p_wr_ram) else $error("write not in RAM in two clocks");
  property p_usb_prio;
    usb_busy_i |=> !(ram_we_o || ram_re_o);
  endproperty
  a_usb_prio: assert property (p_usb_prio) else $error("RAM access during USB");
  property p_addr_inc;
    (ram_we_o || ram_re_o) && mem_en_i |-> addr_q == addr_inc(ram_addr_o);
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address did not count");
  property p_addr_load;
    !mem_en_i |=> addr_q == $past(begin_addr_i);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("begin address not loaded");
  property p_dack_alias;
    (wr_rise && dma_ack_en_i && !prev_q[ehp_pkg::PIN_DACK]) |-> mem_sel && !cpu_sel;
  endproperty
  a_dack_alias: assert property (p_dack_alias) else $error("ack access not memory");
  property p_burst_req;
    (burst_i && mem_en_i && !done_q) |=> mreq_q;
  endproperty
  a_burst_req: assert property (p_burst_req) else $error("burst request dropped");
  property p_single_drop;
    (!burst_i && mem_fall) |=> !mreq_q [*2];
  endproperty
  a_single_drop: assert property (p_single_drop) else $error("request held in access");
  property p_prefetch;
    (rd_mem_ev && !usb_busy_i && st_q == ehp_pkg::EHP_IDLE && !cpu_tx_load_i) |-> s_fetch;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("next byte not fetched");
endmodule // ehp_external_host_port
`default_nettype wire

// file: sim/ehp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// external controller on the host port: strobes and selects idle high
module ehp_host_model (
  input wire logic ref_clk_i,
  output logic cs_n_o,
  output logic a0_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic dack_n_o,
  input wire logic [7:0] dev_dq_i,
  input wire logic dev_oe_i,
  output logic [7:0] dq_o
);
  logic [7:0] drv = 8'h3c;
  // no pull on the data lines, so a released bus shows flipped bits
  assign dq_o = dev_oe_i ? dev_dq_i : drv;
  initial begin
    {cs_n_o, rd_n_o, wr_n_o, dack_n_o} = 4'hf;
    a0_o = 1'b0;
  end
  // one byte access; select and data stand until after the strobe rise
  task automatic access(input logic dack, input logic a0, input logic wr,
                        input logic [7:0] wd, output logic [7:0] rd);
    @(negedge ref_clk_i);
    cs_n_o = dack;
    dack_n_o = ~dack;
    a0_o = a0;
    repeat (2) @(negedge ref_clk_i);
    if (wr) begin
      drv = wd;
      wr_n_o = 1'b0;
    end else begin
      rd_n_o = 1'b0;
    end
    repeat (6) @(negedge ref_clk_i);
    rd = dq_o;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    @(negedge ref_clk_i);
    cs_n_o = 1'b1;
    dack_n_o = 1'b1;
    drv = ~drv;
    // gap covers sync, two-clock move and the worst usb wait
    repeat (10) @(negedge ref_clk_i);
  endtask
endmodule // ehp_host_model
`default_nettype wire

// file: sim/ehp_external_host_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ehp_external_host_port_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, a0, rd_n, wr_n, dack_n, dq_oe, h_irq, dreq, done, cpu_irq, rx_full, tx_full;
  logic ram_we, ram_re, dreq_en, dack_en, tc_en, ssel_en, port_dreq, tc, ssel;
  logic mem_en, dir, burst, take, load, usb, dreq_q;
  logic [1:0] isel;
  logic [2:0] port_in;
  logic [7:0] dq_pin, dq_o, rx_data, wdata, rdata, txd, d, r, tmp;
  logic [10:0] ram_addr, badr, eadr;
  logic [31:0] lf = 32'h000178b3;
  logic [31:0] ulf = 32'h000178b3;
  logic [7:0] ram [0:2047];
  logic [7:0] expv [0:7];
  int mismatches = 0;
  int checks = 0;
  int irq_n = 0;
  int rise_n = 0;
  int fall_n = 0;
  int n;

  always #25 clk = ~clk;

  ehp_host_model i_ehp_host_model (.ref_clk_i(clk), .cs_n_o(cs_n), .a0_o(a0), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .dack_n_o(dack_n), .dev_dq_i(dq_o), .dev_oe_i(dq_oe), .dq_o(dq_pin));

  ehp_external_host_port i_ehp_external_host_port (.ref_clk_i(clk), .rst_i(rst),
    .ext_chip_select_n_i(cs_n), .ext_addr_bit0_i(a0), .ext_read_strobe_n_i(rd_n),
    .ext_write_strobe_n_i(wr_n), .host_data_lines_i(dq_pin), .host_data_lines_o(dq_o),
    .host_data_lines_oe_o(dq_oe), .host_irq_out_o(h_irq), .dma_request_out_o(dreq),
    .dma_ack_in_n_i(dack_n), .terminal_count_in_i(tc), .status_select_in_i(ssel),
    .dma_req_en_i(dreq_en), .dma_ack_en_i(dack_en), .tc_en_i(tc_en),
    .status_sel_en_i(ssel_en), .port_dreq_i(port_dreq), .port_in_o(port_in),
    .irq_sel_i(isel), .mem_en_i(mem_en), .mem_read_dir_i(dir), .burst_i(burst),
    .begin_addr_i(badr), .end_addr_i(eadr), .mem_done_o(done), .cpu_irq_o(cpu_irq),
    .cpu_rx_data_o(rx_data), .cpu_rx_full_o(rx_full), .cpu_rx_take_i(take),
    .cpu_tx_load_i(load), .cpu_tx_data_i(txd), .cpu_tx_full_o(tx_full), .usb_busy_i(usb),
    .ram_we_o(ram_we), .ram_re_o(ram_re), .ram_addr_o(ram_addr), .ram_wdata_o(wdata),
    .ram_rdata_i(rdata));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] stat_exp(input logic rxf, input logic txf);
    return {6'h00, txf, rxf};
  endfunction

  // usb steals the ram about one cycle in four, from its own sequence
  always @(negedge clk) begin
    ulf <= lfsr_next(ulf);
    usb <= ulf[0] & ulf[1];
  end

  // ram model: write data stands together with the write strobe
  always @(posedge clk) begin
    if (ram_we === 1'b1) ram[ram_addr] <= wdata;
    rdata <= (ram_re === 1'b1) ? ram[ram_addr] : ~rdata;
    if (cpu_irq === 1'b1) irq_n++;
    dreq_q <= dreq;
    if (dreq === 1'b1 && dreq_q === 1'b0) rise_n++;
    if (dreq === 1'b0 && dreq_q === 1'b1) fall_n++;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      mismatches++;
      $display("Error %0t: byte %h expected %h", $time, got, want);
    end
  endtask

  task automatic chk_bit(input logic got, input logic want);
    checks++;
    if (got !== want) begin
      mismatches++;
      $display("Error %0t: flag %b expected %b", $time, got, want);
    end
  endtask

  task automatic ram_chk(input logic [10:0] base, input int cnt);
    for (int i = 0; i < cnt; i++) chk_byte(ram[base + i], expv[i]);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // a hang ends the run the same way as the tests do
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    {dreq_en, dack_en, tc_en, ssel_en, port_dreq, tc, ssel, mem_en, dir, burst, take, load} = '0;
    {isel, badr, eadr, txd} = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // pins keep their ordinary function until enabled
    port_dreq = 1'b1;
    ssel = 1'b1;
    repeat (4) @(negedge clk);
    chk_bit(dreq, 1'b1);
    chk_byte({5'h00, port_in}, 8'h05);
    {port_dreq, ssel} = 2'h0;
    // processor path, both directions, with status and irq sources
    for (int i = 0; i < 3; i++) begin
      d = lf[7:0];
      lf = lfsr_next(lf);
      n = irq_n;
      i_ehp_host_model.access(1'b0, 1'b1, 1'b1, d, r);
      chk_byte(rx_data, d);
      chk_byte(8'(irq_n - n), 8'h01);
      chk_bit(rx_full, 1'b1);
      if (i == 0) begin
        {ssel_en, ssel} = 2'h3;
        i_ehp_host_model.access(1'b0, 1'b0, 1'b0, 8'h00, r);
        chk_byte(r, stat_exp(1'b1, 1'b0));
        {ssel_en, ssel} = 2'h0;
      end
      isel = ehp_pkg::IRQ_SEL_RX;
      repeat (3) @(negedge clk);
      chk_bit(h_irq, 1'b0);
      take = 1'b1;
      @(negedge clk);
      take = 1'b0;
      repeat (3) @(negedge clk);
      chk_bit(rx_full, 1'b0);
      chk_bit(h_irq, 1'b1);
      isel = ehp_pkg::IRQ_SEL_TX;
      txd = ~d;
      load = 1'b1;
      @(negedge clk);
      load = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit(tx_full, 1'b1);
      chk_bit(h_irq, 1'b1);
      n = irq_n;
      i_ehp_host_model.access(1'b0, 1'b1, 1'b0, 8'h00, r);
      chk_byte(r, ~d);
      chk_byte(8'(irq_n - n), 8'h01);
      chk_bit(tx_full, 1'b0);
    end
    // memory write, per-byte requests, one access by acknowledge, ended by tc
    tmp = lf[7:0];
    badr = {tmp[6:0], 4'h0};
    eadr = badr + 11'h00f;
    ram[badr + 6] = 8'h5a;
    {dreq_en, dack_en, tc_en} = 3'h7;
    @(negedge clk);
    mem_en = 1'b1;
    n = rise_n;
    for (int i = 0; i < 6; i++) begin
      lf = lfsr_next(lf);
      expv[i] = lf[7:0];
      tc = (i == 5);
      i_ehp_host_model.access(i == 2, 1'b0, 1'b1, expv[i], r);
      tc = 1'b0;
    end
    i_ehp_host_model.access(1'b0, 1'b0, 1'b1, 8'ha5, r);
    ram_chk(badr, 6);
    chk_byte(ram[badr + 6], 8'h5a);
    chk_bit(done, 1'b1);
    chk_byte(8'(rise_n - n), 8'h06);
    // memory read from a prefetched window ending at the end address
    mem_en = 1'b0;
    tc_en = 1'b0;
    dir = 1'b1;
    badr = {tmp[6:0], 4'h8};
    eadr = badr + 11'h004;
    for (int i = 0; i < 5; i++) ram[badr + i] = 8'(lfsr_next(lf + 32'(i)) >> 3);
    @(negedge clk);
    mem_en = 1'b1;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      i_ehp_host_model.access(1'b0, 1'b0, 1'b0, 8'h00, r);
      chk_byte(r, ram[badr + i]);
    end
    chk_bit(done, 1'b1);
    // burst: request stays up from start to end address
    mem_en = 1'b0;
    {dir, burst} = 2'h1;
    badr = 11'h700;
    eadr = 11'h703;
    isel = ehp_pkg::IRQ_SEL_MREQ;
    @(negedge clk);
    mem_en = 1'b1;
    repeat (3) @(negedge clk);
    n = fall_n;
    chk_bit(dreq, 1'b1);
    chk_bit(h_irq, 1'b1);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr_next(lf);
      expv[i] = lf[7:0];
      i_ehp_host_model.access(1'b0, 1'b0, 1'b1, expv[i], r);
    end
    ram_chk(badr, 4);
    chk_byte(8'(fall_n - n), 8'h01);
    chk_bit(dreq, 1'b0);
    chk_bit(done, 1'b1);
    // the unused interrupt source code keeps the host pin quiet
    isel = 2'h3;
    repeat (2) @(negedge clk);
    chk_bit(h_irq, 1'b0);
    give_verdict();
  end
endmodule // ehp_external_host_port_tb_top
`default_nettype wire
